// File: card_host_packet_cmd_dma3_reset_tb_top.sv
`timescale 1ns/10ps
module card_host_packet_cmd_dma3_reset_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, lclk = 1'b0, ans = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd, daddr, resp = 32'h0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, tx, rx, rp, rn, pwr;
    logic dreq, dack = 1'b0, dlast = 1'b0, derr = 1'b0, a;
    int error_cnt = 0;
    int check_count = 0;
    initial forever #2.5 clk_i = ~clk_i;
    initial forever #62.5 lclk = ~lclk;
    chp_host_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .link_clk_i(lclk),
        .lane_rx_i(rx), .lane_tx_o(tx), .refclk_p_o(rp), .refclk_n_o(rn),
        .card_bus_power_o(pwr), .dma_req_o(dreq), .dma_addr_o(daddr),
        .dma_ack_i(dack), .dma_last_i(dlast), .dma_err_i(derr));
    chp_card_model card_u (.link_clk_i(lclk), .lane_tx_i(tx),
        .answer_i(ans), .resp_word_i(resp), .lane_rx_o(rx));
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [7:0] ad, input logic [31:0] m, e);
        wb(1'b0, ad, 32'h0);
        ck(rd & m, e);
    endtask
    task automatic pl(input logic [7:0] ad, input logic [31:0] m, e);
        int n;
        n = 0;
        do begin
            wb(1'b0, ad, 32'h0);
            n++;
        end while ((rd & m) !== e && n < 3000);
        ck(rd & m, e);
    endtask
    task automatic dh(input logic l, input logic e);
        dack <= 1'b1;
        dlast <= l;
        derr <= e;
        @(posedge clk_i);
        dack <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        #300000;
        error_cnt++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rc(8'hFC, 32'hFFFF_FFFF, 32'h0);
        ck({31'h0, pwr}, 32'h0);
        wb(1'b1, chp_pkg::OFS_POWER, 32'h1);
        wb(1'b1, chp_pkg::OFS_BLK_SIZE, 32'h200);
        wb(1'b1, chp_pkg::OFS_BLK_COUNT, 32'h1);
        wb(1'b1, 8'h40, {24'h0, chp_pkg::CODE_GO_DORMANT});
        wb(1'b1, 8'h44, 32'h1234_5678);
        wb(1'b1, chp_pkg::OFS_XFER_MODE, 32'h2);
        wb(1'b1, chp_pkg::OFS_CMD, 32'h2);
        rc(chp_pkg::OFS_PRESENT, 32'h2, 32'h2);
        pl(chp_pkg::OFS_INT_STATUS, 32'h1, 32'h1);
        rc(chp_pkg::OFS_RESPONSE, 32'hFFFF_FFFF, 32'h0D);
        rc(chp_pkg::OFS_PRESENT, 32'h1, 32'h1);
        wb(1'b1, chp_pkg::OFS_INT_STATUS, 32'h1);
        rc(chp_pkg::OFS_INT_STATUS, 32'h1, 32'h0);
        $display("broadcast test done");
        resp = 32'h0000_A5C3;
        ans <= 1'b1;
        wb(1'b1, chp_pkg::OFS_XFER_MODE, 32'h0);
        wb(1'b1, chp_pkg::OFS_CMD, 32'h1);
        rc(chp_pkg::OFS_INT_STATUS, 32'h1, 32'h0);
        pl(chp_pkg::OFS_INT_STATUS, 32'h1, 32'h1);
        rc(chp_pkg::OFS_RESPONSE, 32'hFFFF_FFFF, 32'hA5C3);
        wb(1'b1, chp_pkg::OFS_INT_STATUS, 32'h1);
        resp = 32'h0000_8001;
        wb(1'b1, chp_pkg::OFS_XFER_MODE, 32'h1);
        wb(1'b1, chp_pkg::OFS_CMD, 32'h1);
        pl(chp_pkg::OFS_INT_STATUS, 32'h4, 32'h4);
        rc(chp_pkg::OFS_INT_STATUS, 32'h1, 32'h0);
        rc(chp_pkg::OFS_RESP_CTRL, 32'h1, 32'h1);
        $display("response test done");
        wb(1'b1, chp_pkg::OFS_CLK_CTRL, 32'h1);
        repeat (8) @(posedge clk_i);
        a = rp;
        repeat (4) @(posedge clk_i);
        ck({31'h0, rp}, {31'h0, ~a});
        wb(1'b1, chp_pkg::OFS_CLK_CTRL, 32'h0);
        ck({30'h0, rp, rn}, 32'h0);
        ck({31'h0, pwr}, 32'h1);
        wb(1'b1, chp_pkg::OFS_HOST_CTRL1, 32'h0);
        wb(1'b1, chp_pkg::OFS_IDMA_ADDR, 32'h100);
        ck({31'h0, dreq}, 32'h0);
        wb(1'b1, chp_pkg::OFS_HOST_CTRL1, 32'h3);
        wb(1'b1, chp_pkg::OFS_IDMA_ADDR, 32'h1000);
        ck({dreq, daddr}, {1'b1, 32'h1000});
        dh(1'b0, 1'b0);
        ck(daddr, 32'h1010);
        dh(1'b1, 1'b0);
        pl(chp_pkg::OFS_INT_STATUS, 32'h2, 32'h2);
        wb(1'b1, chp_pkg::OFS_INT_STATUS, 32'h2);
        rc(chp_pkg::OFS_INT_STATUS, 32'h2, 32'h0);
        wb(1'b1, chp_pkg::OFS_IDMA_ADDR, 32'h2000);
        dh(1'b0, 1'b1);
        pl(chp_pkg::OFS_INT_STATUS, 32'h8, 32'h8);
        rc(chp_pkg::OFS_DMA_SYS_ADDR, 32'hFFFF_FFFF, 32'h2000);
        rc(chp_pkg::OFS_DMA_ERR_STAT, 32'h3, 32'h1);
        wb(1'b1, chp_pkg::OFS_INT_STATUS, 32'h8);
        rc(chp_pkg::OFS_INT_STATUS, 32'h8, 32'h0);
        $display("dma test done");
        wb(1'b1, chp_pkg::OFS_POWER, 32'h1);
        wb(1'b1, chp_pkg::OFS_SW_RESET, 32'h1);
        ck({31'h0, pwr}, 32'h1);
        pl(chp_pkg::OFS_SW_RESET, 32'h1, 32'h0);
        ck({31'h0, pwr}, 32'h1);
        rc(chp_pkg::OFS_HOST_CTRL1, 32'h3, 32'h0);
        wb(1'b1, chp_pkg::OFS_CLK_CTRL, 32'h1);
        rc(chp_pkg::OFS_CLK_CTRL, 32'h1, 32'h1);
        wb(1'b1, chp_pkg::OFS_SW_RESET, 32'h2);
        pl(chp_pkg::OFS_SW_RESET, 32'h2, 32'h0);
        $display("reset test done");
        test_done;
    end
endmodule // card_host_packet_cmd_dma3_reset_tb_top

// File: chp_card_model.sv
`timescale 1ns/10ps
module chp_card_model (
    input wire logic link_clk_i,
    input wire logic lane_tx_i,
    input wire logic answer_i,
    input wire logic [31:0] resp_word_i,
    output logic lane_rx_o
);
    // ----------------------------------------
    // card answers once the host lane goes quiet
    // ----------------------------------------
    int quiet = 0;
    logic seen = 1'b0;
    initial begin
        lane_rx_o = 1'b0;
        forever begin
            @(posedge link_clk_i);
            quiet = lane_tx_i ? 0 : quiet + 1;
            seen = seen | lane_tx_i;
            if (seen && quiet == 40) begin
                seen = 1'b0;
                if (answer_i) begin
                    @(negedge link_clk_i) lane_rx_o = 1'b1;
                    for (int i = 31; i >= 0; i--) begin
                        @(negedge link_clk_i) lane_rx_o = resp_word_i[i];
                    end
                    // pull-down idle level
                    @(negedge link_clk_i) lane_rx_o = 1'b0;
                end
            end
        end
    end
endmodule // chp_card_model

// File: chp_host_ctrl.sv
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/10ps
module chp_host_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic link_clk_i,
    input wire logic lane_rx_i,
    output logic lane_tx_o,
    output logic refclk_p_o,
    output logic refclk_n_o,
    output logic card_bus_power_o,
    output logic dma_req_o,
    output logic [31:0] dma_addr_o,
    input wire logic dma_ack_i,
    input wire logic dma_last_i,
    input wire logic dma_err_i
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam int RST_WAIT_MAX = 256;
    localparam int CMD_LEN_W_L = chp_pkg::CMD_LEN_W;
    logic acc, wr, launch, dma_start, clr, eng_clr, link_rise, rx_s;
    logic lk1, lk2, lk3, rx1, rx2, ev_done, ev_xfer, ev_dma_err;
    logic ev_resp_err, bcast, resp_dis, in_dormant, card_clk_en;
    logic full_rst, tran_rst, ref_lvl;
    logic [CMD_LEN_W_L-1:0] cmd_len;
    logic [1:0] xfer_mode, dma_sel, dma_err_stat;
    logic [15:0] blk_size, blk_count;
    logic [31:0] idma_addr, resp, header, dma_sys_addr, mem_rdata;
    logic [31:0] rxsh;
    logic [32:0] shreg;
    logic [5:0] bitcnt;
    logic [3:0] idx;
    logic [7:0] rst_cnt, ref_cnt;
    logic [chp_pkg::INT_W-1:0] int_status, int_set, int_w1c;
    chp_pkg::chp_tx_state_t state;
    chp_pkg::chp_dma_state_t dstate;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] ofs);
        return wr && (wb_adr_i == ofs);
    endfunction

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = acc && wb_we_i;
    assign clr = rst_i || full_rst;
    assign eng_clr = clr || tran_rst;
    assign bcast = xfer_mode[chp_pkg::XM_BROADCAST];
    assign resp_dis = xfer_mode[chp_pkg::XM_RESP_IRQ_DIS];
    assign launch = hit(chp_pkg::OFS_CMD) && wb_sel_i[0]
        && (wb_dat_i[CMD_LEN_W_L-1:0] != '0) && (state == chp_pkg::TX_IDLE);
    assign dma_start = hit(chp_pkg::OFS_IDMA_ADDR)
        && (dma_sel == chp_pkg::DMA_SEL_IDMA) && (dstate == chp_pkg::DMA_IDLE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= '0;
            if (acc && !wb_we_i) begin
                case (wb_adr_i)
                    chp_pkg::OFS_CMD: wb_dat_o <= 32'(cmd_len);
                    chp_pkg::OFS_XFER_MODE: wb_dat_o <= 32'(xfer_mode);
                    chp_pkg::OFS_BLK_SIZE: wb_dat_o <= 32'(blk_size);
                    chp_pkg::OFS_BLK_COUNT: wb_dat_o <= 32'(blk_count);
                    chp_pkg::OFS_HOST_CTRL1: wb_dat_o <= 32'(dma_sel);
                    chp_pkg::OFS_IDMA_ADDR: wb_dat_o <= idma_addr;
                    chp_pkg::OFS_INT_STATUS: wb_dat_o <= 32'(int_status);
                    chp_pkg::OFS_RESPONSE: wb_dat_o <= resp;
                    chp_pkg::OFS_DMA_SYS_ADDR: wb_dat_o <= dma_sys_addr;
                    chp_pkg::OFS_DMA_ERR_STAT: wb_dat_o <= 32'(dma_err_stat);
                    chp_pkg::OFS_PRESENT: wb_dat_o <= 32'({
                        dstate == chp_pkg::DMA_FETCH,
                        state != chp_pkg::TX_IDLE, in_dormant});
                    chp_pkg::OFS_CLK_CTRL: wb_dat_o <= 32'(card_clk_en);
                    chp_pkg::OFS_POWER: wb_dat_o <= 32'(card_bus_power_o);
                    chp_pkg::OFS_SW_RESET: wb_dat_o <= 32'({tran_rst, full_rst});
                    chp_pkg::OFS_RESP_CTRL: wb_dat_o <= 32'(resp_dis);
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (clr) begin
            cmd_len <= '0;
            xfer_mode <= '0;
            blk_size <= '0;
            blk_count <= '0;
            dma_sel <= '0;
            idma_addr <= '0;
            card_clk_en <= 1'b0;
        end else begin
            if (hit(chp_pkg::OFS_CMD)) begin
                cmd_len <= CMD_LEN_W_L'(merge(32'(cmd_len), wb_dat_i, wb_sel_i));
            end
            if (hit(chp_pkg::OFS_XFER_MODE)) begin
                xfer_mode <= 2'(merge(32'(xfer_mode), wb_dat_i, wb_sel_i));
            end
            if (hit(chp_pkg::OFS_BLK_SIZE)) begin
                blk_size <= 16'(merge(32'(blk_size), wb_dat_i, wb_sel_i));
            end
            if (hit(chp_pkg::OFS_BLK_COUNT)) begin
                blk_count <= 16'(merge(32'(blk_count), wb_dat_i, wb_sel_i));
            end
            if (hit(chp_pkg::OFS_HOST_CTRL1)) begin
                dma_sel <= 2'(merge(32'(dma_sel), wb_dat_i, wb_sel_i));
            end
            if (hit(chp_pkg::OFS_IDMA_ADDR)) begin
                idma_addr <= merge(idma_addr, wb_dat_i, wb_sel_i);
            end
            if (hit(chp_pkg::OFS_CLK_CTRL)) begin
                card_clk_en <= 1'(merge(32'(card_clk_en), wb_dat_i, wb_sel_i));
            end
        end
    end

    // bus power only follows the hard reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            card_bus_power_o <= 1'b0;
        end else if (hit(chp_pkg::OFS_POWER) && wb_sel_i[0]) begin
            card_bus_power_o <= wb_dat_i[0];
        end
    end

    // ----------------------------------------
    // software resets
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_rst <= 1'b0;
            tran_rst <= 1'b0;
            rst_cnt <= '0;
        end else if (full_rst || tran_rst) begin
            rst_cnt <= rst_cnt + 8'h01;
            if (full_rst && rst_cnt == 8'(chp_pkg::FULL_RESET_CYC - 1)) begin
                full_rst <= 1'b0;
                tran_rst <= 1'b0;
                rst_cnt <= '0;
            end else if (!full_rst
                    && rst_cnt == 8'(chp_pkg::TRAN_RESET_CYC - 1)) begin
                tran_rst <= 1'b0;
                rst_cnt <= '0;
            end
        end else if (hit(chp_pkg::OFS_SW_RESET) && wb_sel_i[0]) begin
            full_rst <= wb_dat_i[chp_pkg::SWR_FULL];
            tran_rst <= wb_dat_i[chp_pkg::SWR_TRAN];
        end
    end

    // ----------------------------------------
    // link clock and lane synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        lk1 <= link_clk_i;
        lk2 <= lk1;
        lk3 <= lk2;
        rx1 <= lane_rx_i;
        rx2 <= rx1;
    end
    assign link_rise = lk2 && !lk3;
    assign rx_s = rx2;

    // ----------------------------------------
    // command packet engine
    // ----------------------------------------
    chp_pkt_mem u_mem (
        .clk_i(clk_i),
        .we_i(wr && wb_adr_i[7:6] == chp_pkg::PKT_REGION),
        .waddr_i(wb_adr_i[5:2]),
        .wdata_i(wb_dat_i),
        .raddr_i(idx),
        .rdata_o(mem_rdata)
    );

    always_ff @(posedge clk_i) begin
        ev_done <= 1'b0;
        ev_resp_err <= 1'b0;
        if (eng_clr) begin
            state <= chp_pkg::TX_IDLE;
            idx <= '0;
            bitcnt <= '0;
            shreg <= '0;
            rxsh <= '0;
            header <= '0;
            resp <= '0;
            lane_tx_o <= 1'b0;
        end else begin
            if (link_rise && state != chp_pkg::TX_SHIFT) begin
                lane_tx_o <= 1'b0;
            end
            case (state)
                chp_pkg::TX_IDLE: begin
                    if (launch) begin
                        idx <= '0;
                        state <= chp_pkg::TX_READ;
                    end
                end
                chp_pkg::TX_READ: state <= chp_pkg::TX_LOAD;
                chp_pkg::TX_LOAD: begin
                    shreg <= {1'b1, mem_rdata};
                    bitcnt <= '0;
                    if (idx == '0) begin
                        header <= mem_rdata;
                    end
                    state <= chp_pkg::TX_SHIFT;
                end
                chp_pkg::TX_SHIFT: begin
                    if (link_rise) begin
                        lane_tx_o <= shreg[32];
                        shreg <= {shreg[31:0], 1'b0};
                        bitcnt <= bitcnt + 6'h01;
                        if (bitcnt == chp_pkg::WORD_LAST_BIT) begin
                            if (5'(idx) + 5'h01 < cmd_len) begin
                                idx <= idx + 4'h1;
                                state <= chp_pkg::TX_READ;
                            end else if (bcast) begin
                                resp <= header;
                                ev_done <= 1'b1;
                                state <= chp_pkg::TX_IDLE;
                            end else begin
                                state <= chp_pkg::TX_RESP_WAIT;
                            end
                        end
                    end
                end
                chp_pkg::TX_RESP_WAIT: begin
                    if (link_rise && rx_s) begin
                        bitcnt <= '0;
                        state <= chp_pkg::TX_RESP_BITS;
                    end
                end
                chp_pkg::TX_RESP_BITS: begin
                    if (link_rise) begin
                        rxsh <= {rxsh[30:0], rx_s};
                        bitcnt <= bitcnt + 6'h01;
                        if (bitcnt == chp_pkg::RESP_LAST_BIT) begin
                            resp <= {rxsh[30:0], rx_s};
                            ev_done <= 1'b1;
                            ev_resp_err <= resp_dis
                                && rxsh[chp_pkg::RESP_NACK_BIT - 1];
                            state <= chp_pkg::TX_IDLE;
                        end
                    end
                end
                default: state <= chp_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (eng_clr) begin
            in_dormant <= 1'b0;
        end else if (ev_done && header[7:0] == chp_pkg::CODE_GO_DORMANT) begin
            in_dormant <= 1'b1;
        end else if (launch) begin
            in_dormant <= 1'b0;
        end
    end

    // ----------------------------------------
    // descriptor dma
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        ev_xfer <= 1'b0;
        ev_dma_err <= 1'b0;
        if (clr) begin
            dstate <= chp_pkg::DMA_IDLE;
            dma_req_o <= 1'b0;
            dma_addr_o <= '0;
            dma_sys_addr <= '0;
            dma_err_stat <= '0;
        end else begin
            case (dstate)
                chp_pkg::DMA_IDLE: begin
                    if (dma_start) begin
                        dma_addr_o <= merge(idma_addr, wb_dat_i, wb_sel_i);
                        dma_sys_addr <= merge(idma_addr, wb_dat_i, wb_sel_i);
                        dma_req_o <= 1'b1;
                        dstate <= chp_pkg::DMA_FETCH;
                    end
                end
                chp_pkg::DMA_FETCH: begin
                    if (dma_ack_i) begin
                        if (dma_err_i) begin
                            dma_err_stat <= chp_pkg::DMA_ERR_FETCH;
                            ev_dma_err <= 1'b1;
                            dma_req_o <= 1'b0;
                            dstate <= chp_pkg::DMA_IDLE;
                        end else if (dma_last_i) begin
                            ev_xfer <= 1'b1;
                            dma_req_o <= 1'b0;
                            dstate <= chp_pkg::DMA_IDLE;
                        end else begin
                            dma_addr_o <= dma_addr_o + chp_pkg::DESC_BYTES;
                            dma_sys_addr <= dma_addr_o + chp_pkg::DESC_BYTES;
                        end
                    end
                end
                default: dstate <= chp_pkg::DMA_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // status, write one to clear, set wins
    // ----------------------------------------
    always_comb begin
        int_set = '0;
        int_set[chp_pkg::INT_CMD] = ev_done && (bcast || !resp_dis);
        int_set[chp_pkg::INT_XFER] = ev_xfer;
        int_set[chp_pkg::INT_RESP_ERR] = ev_resp_err;
        int_set[chp_pkg::INT_DMA_ERR] = ev_dma_err;
        int_w1c = '0;
        if (hit(chp_pkg::OFS_INT_STATUS) && wb_sel_i[0]) begin
            int_w1c = wb_dat_i[chp_pkg::INT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~int_w1c) | int_set;
        end
    end

    // ----------------------------------------
    // reference clock divider
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (clr || !card_clk_en) begin
            ref_cnt <= '0;
            ref_lvl <= 1'b0;
            refclk_p_o <= 1'b0;
            refclk_n_o <= 1'b0;
        end else begin
            ref_cnt <= ref_cnt + 8'h01;
            if (ref_cnt == 8'(chp_pkg::REFCLK_HALF_CYC - 1)) begin
                ref_cnt <= '0;
                ref_lvl <= !ref_lvl;
            end
            refclk_p_o <= ref_lvl;
            refclk_n_o <= !ref_lvl;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_launch;
        launch;
    endsequence
    sequence s_cmd_clear;
        wr && wb_adr_i == chp_pkg::OFS_INT_STATUS && wb_sel_i[0]
            && wb_dat_i[chp_pkg::INT_CMD] && !int_set[chp_pkg::INT_CMD];
    endsequence

    property p_launch;
        s_launch |=> state == chp_pkg::TX_READ ##1 state == chp_pkg::TX_LOAD;
    endproperty
    a_launch: assert property (p_launch) else $error("launch lost");

    property p_bcast;
        ev_done && bcast |-> resp == header ##1 int_status[chp_pkg::INT_CMD];
    endproperty
    a_bcast: assert property (p_bcast) else $error("bcast done bad");

    property p_cmd_w1c;
        s_cmd_clear |=> !int_status[chp_pkg::INT_CMD];
    endproperty
    a_cmd_w1c: assert property (p_cmd_w1c) else $error("w1c failed");

    property p_dma_sel;
        wr && wb_adr_i == chp_pkg::OFS_IDMA_ADDR
            && dstate == chp_pkg::DMA_IDLE
            |=> dma_req_o == ($past(dma_sel) == chp_pkg::DMA_SEL_IDMA);
    endproperty
    a_dma_sel: assert property (p_dma_sel)
        else $error("dma start bad");

    property p_dma_err;
        dma_req_o && dma_ack_i && dma_err_i |=> !dma_req_o
            && dma_sys_addr == $past(dma_addr_o)
            ##1 int_status[chp_pkg::INT_DMA_ERR];
    endproperty
    a_dma_err: assert property (p_dma_err)
        else $error("dma error bad");

    property p_refclk_stop;
        !card_clk_en && !clr |=> !refclk_p_o && !refclk_n_o;
    endproperty
    a_refclk_stop: assert property (p_refclk_stop)
        else $error("refclk on");

    property p_full_clear;
        $rose(full_rst) |-> ##[1:RST_WAIT_MAX] !full_rst;
    endproperty
    a_full_clear: assert property (p_full_clear)
        else $error("full stuck");

    property p_power_keep;
        full_rst && card_bus_power_o |=> card_bus_power_o;
    endproperty
    a_power_keep: assert property (p_power_keep)
        else $error("power lost");

    property p_dormant;
        ev_done && header[7:0] == chp_pkg::CODE_GO_DORMANT && !eng_clr
            |=> in_dormant;
    endproperty
    a_dormant: assert property (p_dormant) else $error("no dormant");

    property p_tran_clear;
        $rose(tran_rst) |-> ##[1:RST_WAIT_MAX] !tran_rst;
    endproperty
    a_tran_clear: assert property (p_tran_clear)
        else $error("tran stuck");
endmodule // chp_host_ctrl

// File: chp_pkg.sv
package chp_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_XFER_MODE = 8'h08;
    localparam logic [7:0] OFS_BLK_SIZE = 8'h0C;
    localparam logic [7:0] OFS_BLK_COUNT = 8'h10;
    localparam logic [7:0] OFS_HOST_CTRL1 = 8'h14;
    localparam logic [7:0] OFS_IDMA_ADDR = 8'h18;
    localparam logic [7:0] OFS_INT_STATUS = 8'h1C;
    localparam logic [7:0] OFS_RESPONSE = 8'h20;
    localparam logic [7:0] OFS_DMA_SYS_ADDR = 8'h24;
    localparam logic [7:0] OFS_DMA_ERR_STAT = 8'h28;
    localparam logic [7:0] OFS_PRESENT = 8'h2C;
    localparam logic [7:0] OFS_CLK_CTRL = 8'h30;
    localparam logic [7:0] OFS_POWER = 8'h34;
    localparam logic [7:0] OFS_SW_RESET = 8'h38;
    localparam logic [7:0] OFS_RESP_CTRL = 8'h3C;
    localparam logic [1:0] PKT_REGION = 2'h1;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int PKT_DEPTH = 16;
    localparam int PKT_AW = 4;
    localparam int CMD_LEN_W = 5;
    localparam int XM_RESP_IRQ_DIS = 0;
    localparam int XM_BROADCAST = 1;
    localparam logic [1:0] DMA_SEL_IDMA = 2'h3;
    localparam int INT_W = 4;
    localparam int INT_CMD = 0;
    localparam int INT_XFER = 1;
    localparam int INT_RESP_ERR = 2;
    localparam int INT_DMA_ERR = 3;
    localparam int PS_DORMANT = 0;
    localparam int PS_CMD_BUSY = 1;
    localparam int PS_DMA_BUSY = 2;
    localparam int SWR_FULL = 0;
    localparam int SWR_TRAN = 1;
    localparam int RESP_NACK_BIT = 15;
    localparam logic [7:0] CODE_GO_DORMANT = 8'h0D;
    localparam logic [1:0] DMA_ERR_FETCH = 2'h1;
    localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
    localparam logic [5:0] WORD_LAST_BIT = 6'h20;
    localparam logic [5:0] RESP_LAST_BIT = 6'h1F;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 5;
    localparam int REFCLK_HALF_NS = 20;
    localparam int FULL_RESET_NS = 1000;
    localparam int TRAN_RESET_NS = 500;
    localparam int REFCLK_HALF_CYC = (REFCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int FULL_RESET_CYC = (FULL_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRAN_RESET_CYC = (TRAN_RESET_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        TX_IDLE, TX_READ, TX_LOAD, TX_SHIFT, TX_RESP_WAIT, TX_RESP_BITS
    } chp_tx_state_t;

    typedef enum logic {DMA_IDLE, DMA_FETCH} chp_dma_state_t;

endpackage

// File: chp_pkt_mem.sv
`timescale 1ns/10ps
module chp_pkt_mem (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] raddr_i,
    output logic [31:0] rdata_o
);
    // ----------------------------------------
    // command packet storage
    // ----------------------------------------
    logic [31:0] mem [chp_pkg::PKT_DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule // chp_pkt_mem
